// ---- hdl/quad_counter_pkg.sv ----
// Shared constants and types for the dual-axis encoder counter and its host
package quad_counter_pkg;
	localparam int CLK_MHZ = 250;
	localparam int CNT_W = 24;
	localparam int NUM_AXES = 2;
	localparam logic [1:0] BYTE_LAST = 2'h2;
	// Control register select, data bits 6:5 of a control write
	localparam logic [1:0] CSEL_RLD = 2'h0;
	localparam logic [1:0] CSEL_CMR = 2'h1;
	localparam logic [1:0] CSEL_IOR = 2'h2;
	localparam logic [1:0] CSEL_IDR = 2'h3;
	localparam int AXIS_ALL_BIT = 7;
	// Reset/load command bits
	localparam int RLD_RST_BP = 0;
	localparam int RLD_RST_CNT = 1;
	localparam int RLD_PR_TO_CNT = 2;
	localparam int RLD_CNT_TO_OL = 3;
	localparam int RLD_CLR_FLAGS = 4;
	// Counter mode bits
	localparam int CMR_QUAD = 0;
	localparam int CMR_LOAD_PSC = 1;
	// Input/output control bits
	localparam int IOR_LOAD_OL = 0;
	localparam int IOR_GATE = 1;
	localparam int IOR_FLG1_LSB = 2;
	// Index control bits
	localparam int IDR_EN = 0;
	localparam int IDR_HIGH = 1;
	localparam int IDR_ON_RG = 2;
	localparam int IDR_FLG2_LSB = 3;
	// Flag register bit positions
	localparam int FLG_CARRY = 0;
	localparam int FLG_BORROW = 1;
	localparam int FLG_COMPARE = 2;
	localparam int FLG_ERROR = 4;
	localparam int FLG_DIR = 5;
	localparam int FLG_IDX = 6;
	localparam logic [4:0] CTRL_RESET = 5'h00;
	localparam logic [7:0] PSC_RESET = 8'h00;
	// Host strobe timing
	localparam int T_SETUP_NS = 50;
	localparam int T_STROBE_NS = 50;
	localparam int T_GAP_NS = 60;
	localparam logic [4:0] SETUP_CYC = 5'((T_SETUP_NS * CLK_MHZ + 999) / 1000);
	localparam logic [4:0] STROBE_CYC = 5'((T_STROBE_NS * CLK_MHZ + 999) / 1000);
	localparam logic [4:0] GAP_CYC = 5'((T_GAP_NS * CLK_MHZ + 999) / 1000);
	// Host APB map
	localparam logic [7:0] HOST_CMD_OFS = 8'h00;
	localparam logic [7:0] HOST_STAT_OFS = 8'h04;
	localparam int CMD_CD_BIT = 8;
	localparam int CMD_AXIS_BIT = 9;
	localparam int CMD_READ_BIT = 10;
	typedef enum logic [4:0] {
		H_IDLE = 5'b00001,
		H_SETUP = 5'b00010,
		H_STROBE = 5'b00100,
		H_HOLD = 5'b01000,
		H_GAP = 5'b10000
	} host_state_type;
endpackage

// ---- hdl/quad_bus_if.sv ----
// Strobed 8-bit host bus between the counter device and its host
`timescale 1ns/1ps
interface quad_bus_if;
	logic cs_n;
	logic wr_n;
	logic rd_n;
	logic c_d;
	logic axis_sel;
	logic [7:0] host_data;
	logic host_oe_n;
	logic [7:0] dev_data;
	logic dev_oe_n;
	wire [7:0] data_bus;
	// Idle bus floats high through a pull-up
	assign data_bus = !dev_oe_n ? dev_data :
		(!host_oe_n ? host_data : 8'hFF);
	modport device (input cs_n, wr_n, rd_n, c_d, axis_sel, data_bus,
		output dev_data, dev_oe_n);
	modport host (output cs_n, wr_n, rd_n, c_d, axis_sel, host_data,
		host_oe_n, input data_bus);
endinterface

// ---- hdl/quad_counter_device.sv ----
// Dual-axis quadrature counter device with strobed 8-bit host bus
// Functional notes
// - Quadrature inputs filtered then decoded to counts
// - Non-quadrature mode bypasses filter and decoder
// - Non-quadrature: A counts, B high up, low down
// - Load input: direct/index load counter or latch
// - Direct load active low; index polarity selectable
// - Host disables index functions in non-quadrature mode
// - Index accepts quarter and half cycle pulses
// - Reset/gate input: reset, gate, or index reset
// - Gate high enables counting, low disables
// - Flag one: carry, compare, index, carry/borrow
// - Flag two: borrow, direction or error
// - Bytes captured at write strobe rising edge
// - Selected byte driven while read strobe low
// - Strobes ignored unless chip select low
// - Control/data line: low data, high control
// - One 8-bit bidirectional three-state data bus
// - Per-axis 8-bit prescaler divides by n+1
// - Axis select: 0 is X, 1 is Y
// - Control write bit 7 addresses both axes
// - Index synchronised, shown as flag bit 6
// - Y axis identical to X axis
// - Byte pointer advances at strobe trailing edge
`timescale 1ns/1ps
module quad_counter_device
	import quad_counter_pkg::*;
(
	input wire logic I_CLOCK, // System clock
	input wire logic I_RST_B, // Async reset, active low
	input wire logic I_FILTER_CLOCK_INPUT, // Filter clock pin
	input wire logic [1:0] I_CHANNEL_A_INPUT, // Channel A, bit 0 X
	input wire logic [1:0] I_CHANNEL_B_INPUT, // Channel B, bit 0 X
	input wire logic [1:0] I_LOAD_INPUT, // Load/index input
	input wire logic [1:0] I_RESET_OR_GATE_INPUT, // Reset/gate input
	output logic [1:0] O_FLAG_OUTPUT_ONE, // Flag output one
	output logic [1:0] O_FLAG_OUTPUT_TWO, // Flag output two
	quad_bus_if.device bus // Host bus
);
	logic [2:0] fck_sync;
	logic wr_q;
	logic rd_q;
	logic cs_q;
	logic [7:0] flags [NUM_AXES];
	logic [CNT_W-1:0] latch [NUM_AXES];
	logic [1:0] bp [NUM_AXES];

	wire fck_rise = fck_sync[1] & ~fck_sync[2];
	wire wr_done = ~wr_q & bus.wr_n & ~cs_q & ~bus.cs_n;
	wire rd_done = ~rd_q & bus.rd_n & ~cs_q & ~bus.cs_n;
	wire rd_active = ~bus.cs_n & ~bus.rd_n;
	wire ctl_wr = wr_done & bus.c_d;
	wire data_wr = wr_done & ~bus.c_d;
	wire data_rd = rd_done & ~bus.c_d;
	wire [1:0] csel = bus.data_bus[6:5];
	wire [4:0] cval = bus.data_bus[4:0];
	wire [1:0] rd_bp = bus.axis_sel ? bp[1] : bp[0];
	wire [CNT_W-1:0] rd_latch = bus.axis_sel ? latch[1] : latch[0];
	wire [7:0] rd_flags = bus.axis_sel ? flags[1] : flags[0];
	wire [7:0] rd_byte = bus.c_d ? rd_flags : rd_latch[{rd_bp, 3'b000} +: 8];

	always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			fck_sync <= 3'h0;
			wr_q <= 1'b1;
			rd_q <= 1'b1;
			cs_q <= 1'b1;
			bus.dev_oe_n <= 1'b1;
			bus.dev_data <= 8'h00;
		end else begin
			fck_sync <= {fck_sync[1:0], I_FILTER_CLOCK_INPUT};
			wr_q <= bus.wr_n;
			rd_q <= bus.rd_n;
			cs_q <= bus.cs_n;
			bus.dev_oe_n <= ~rd_active;
			bus.dev_data <= rd_byte;
		end
	end

	for (genvar ax = 0; ax < NUM_AXES; ax++) begin : g_axis
		logic [3:0] pin_s1;
		logic [3:0] pin_s2;
		logic a_q;
		logic [4:0] cmr;
		logic [4:0] ior;
		logic [4:0] index_control_register;
		logic [7:0] prescale_value;
		logic [7:0] psc_cnt;
		logic [1:0] samp;
		logic [1:0] filt;
		logic [1:0] filt_q;
		logic idx_q;
		logic carry_ev;
		logic borrow_ev;
		logic [CNT_W-1:0] cnt;
		logic [CNT_W-1:0] pr;

		wire sel = (bus.axis_sel == 1'(ax));
		wire ctl_hit = ctl_wr & (sel | bus.data_bus[AXIS_ALL_BIT]);
		wire data_hit = data_wr & sel;
		wire rd_hit = data_rd & sel;
		wire rld_hit = ctl_hit & (csel == CSEL_RLD);
		wire a_in = pin_s2[0];
		wire b_in = pin_s2[1];
		wire ld_in = pin_s2[2];
		wire rg_in = pin_s2[3];
		wire quad = cmr[CMR_QUAD];
		// Divided filter clock tick every psc+1 filter clock rising edges
		wire tick = fck_rise & (psc_cnt == prescale_value);
		wire idx_en = index_control_register[IDR_EN];
		wire idx_src = index_control_register[IDR_ON_RG] ? rg_in : ld_in;
		wire idx_act = ~(idx_src ^ index_control_register[IDR_HIGH]);
		// Edge of the active level, so pulse width does not matter
		wire idx_pulse = tick & idx_en & idx_act & ~idx_q;
		wire idx_load = idx_pulse & ~index_control_register[IDR_ON_RG];
		wire idx_reset = idx_pulse & index_control_register[IDR_ON_RG];
		wire dir_load = ~(idx_en & ~index_control_register[IDR_ON_RG]) & ~ld_in;
		wire rg_direct = ~ior[IOR_GATE] & ~(idx_en & index_control_register[IDR_ON_RG]);
		wire dir_reset = rg_direct & ~rg_in;
		wire gate_ok = ~ior[IOR_GATE] | rg_in;
		wire q_chg_a = filt[0] ^ filt_q[0];
		wire q_chg_b = filt[1] ^ filt_q[1];
		wire q_step = tick & (q_chg_a ^ q_chg_b);
		// Bypassed decoder in count/direction mode reports no errors
		wire q_err = tick & quad & q_chg_a & q_chg_b;
		wire q_up = ~(filt_q[0] ^ filt[1]);
		wire nq_step = a_in & ~a_q;
		wire step = (quad ? q_step : nq_step) & gate_ok;
		wire up = quad ? q_up : b_in;
		wire carry = step & up & (&cnt);
		wire borrow = step & ~up & (cnt == '0);
		wire cmp = (pr == cnt);
		wire to_latch = (dir_load | idx_load) & ior[IOR_LOAD_OL];
		wire to_cnt = ((dir_load | idx_load) & ~ior[IOR_LOAD_OL])
			| (rld_hit & cval[RLD_PR_TO_CNT]);
		wire clr = rld_hit & cval[RLD_CLR_FLAGS];

		always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
			if (!I_RST_B) begin
				pin_s1 <= 4'hF;
				pin_s2 <= 4'hF;
				a_q <= 1'b1;
				cmr <= CTRL_RESET;
				ior <= CTRL_RESET;
				index_control_register <= CTRL_RESET;
				prescale_value <= PSC_RESET;
				psc_cnt <= PSC_RESET;
			end else begin
				pin_s1 <= {I_RESET_OR_GATE_INPUT[ax], I_LOAD_INPUT[ax],
					I_CHANNEL_B_INPUT[ax], I_CHANNEL_A_INPUT[ax]};
				pin_s2 <= pin_s1;
				a_q <= a_in;
				if (ctl_hit && csel == CSEL_CMR)
					cmr <= cval;
				if (ctl_hit && csel == CSEL_IOR)
					ior <= cval;
				if (ctl_hit && csel == CSEL_IDR)
					index_control_register <= cval;
				if (ctl_hit && csel == CSEL_CMR && cval[CMR_LOAD_PSC])
					prescale_value <= pr[7:0];
				if (fck_rise)
					psc_cnt <= tick ? 8'h00 : psc_cnt + 8'h01;
			end
		end

		// Filter: a level is taken after two equal tick samples
		always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
			if (!I_RST_B) begin
				samp <= 2'h0;
				filt <= 2'h0;
				filt_q <= 2'h0;
				idx_q <= 1'b0;
			end else if (tick) begin
				samp <= {b_in, a_in};
				filt <= (samp == {b_in, a_in}) ? samp : filt;
				filt_q <= filt;
				idx_q <= idx_act;
			end
		end

		always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
			if (!I_RST_B) begin
				cnt <= '0;
				pr <= '0;
				latch[ax] <= '0;
				bp[ax] <= 2'h0;
				flags[ax] <= 8'h00;
				carry_ev <= 1'b0;
				borrow_ev <= 1'b0;
			end else begin
				carry_ev <= carry;
				borrow_ev <= borrow;
				if (dir_reset || idx_reset || (rld_hit && cval[RLD_RST_CNT]))
					cnt <= '0;
				else if (to_cnt)
					cnt <= pr;
				else if (step)
					cnt <= up ? cnt + 24'h00_0001 : cnt - 24'h00_0001;
				if (to_latch || (rld_hit && cval[RLD_CNT_TO_OL]))
					latch[ax] <= cnt;
				if (data_hit)
					pr[{bp[ax], 3'b000} +: 8] <= bus.data_bus;
				if (rld_hit && cval[RLD_RST_BP])
					bp[ax] <= 2'h0;
				else if (data_hit || rd_hit)
					bp[ax] <= (bp[ax] == BYTE_LAST) ? 2'h0 : bp[ax] + 2'h1;
				// Sticky bits: a new event beats a clear in the same cycle
				flags[ax][FLG_CARRY] <= carry | (flags[ax][FLG_CARRY] & ~clr);
				flags[ax][FLG_BORROW] <= borrow | (flags[ax][FLG_BORROW] & ~clr);
				flags[ax][FLG_ERROR] <= q_err | (flags[ax][FLG_ERROR] & ~clr);
				flags[ax][FLG_COMPARE] <= cmp;
				flags[ax][FLG_DIR] <= up;
				flags[ax][FLG_IDX] <= idx_q;
				flags[ax][3] <= 1'b0;
				flags[ax][7] <= 1'b0;
			end
		end

		always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
			if (!I_RST_B) begin
				O_FLAG_OUTPUT_ONE[ax] <= 1'b1;
				O_FLAG_OUTPUT_TWO[ax] <= 1'b1;
			end else begin
				case (ior[IOR_FLG1_LSB +: 2])
					2'h0: O_FLAG_OUTPUT_ONE[ax] <= ~carry_ev;
					2'h1: O_FLAG_OUTPUT_ONE[ax] <= ~cmp;
					2'h2: O_FLAG_OUTPUT_ONE[ax] <= idx_q;
					default: O_FLAG_OUTPUT_ONE[ax] <= ~(carry_ev | borrow_ev);
				endcase
				case (index_control_register[IDR_FLG2_LSB +: 2])
					2'h0: O_FLAG_OUTPUT_TWO[ax] <= ~borrow_ev;
					2'h1: O_FLAG_OUTPUT_TWO[ax] <= flags[ax][FLG_DIR];
					default: O_FLAG_OUTPUT_TWO[ax] <= flags[ax][FLG_ERROR];
				endcase
			end
		end
	end
endmodule

// ---- hdl/quad_host_end.sv ----
// Host end: APB command registers driving the strobed counter bus
`timescale 1ns/1ps
module quad_host_end
	import quad_counter_pkg::*;
(
	input wire logic I_CLOCK, // System clock
	input wire logic I_RST_B, // Async reset, active low
	input wire logic I_PSEL, // APB select
	input wire logic I_PENABLE, // APB enable
	input wire logic I_PWRITE, // APB direction
	input wire logic [7:0] I_PADDR, // APB byte address
	input wire logic [31:0] I_PWDATA, // APB write data
	output logic [31:0] O_PRDATA, // APB read data
	output logic O_PREADY, // APB ready
	output logic O_PSLVERR, // APB error on unmapped address
	quad_bus_if.host bus // Counter bus
);
	host_state_type state;
	logic [4:0] cnt;
	logic busy;
	logic is_read;
	logic [7:0] rd_byte;

	wire setup = I_PSEL & ~I_PENABLE & ~O_PREADY;
	wire done = I_PSEL & I_PENABLE & O_PREADY;
	wire hit_cmd = (I_PADDR == HOST_CMD_OFS);
	wire hit_stat = (I_PADDR == HOST_STAT_OFS);
	// A command while busy is dropped; software polls the busy bit first
	wire start = done & I_PWRITE & hit_cmd & ~busy;
	wire cnt_end = (cnt == 5'h00);

	always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			O_PRDATA <= 32'h0000_0000;
			O_PREADY <= 1'b0;
			O_PSLVERR <= 1'b0;
		end else begin
			O_PREADY <= setup;
			O_PSLVERR <= setup & ~(hit_cmd | hit_stat);
			if (setup)
				O_PRDATA <= hit_stat ?
					{16'h0000, rd_byte, 7'h00, busy} : 32'h0000_0000;
		end
	end

	always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			state <= H_IDLE;
			cnt <= 5'h00;
			busy <= 1'b0;
			is_read <= 1'b0;
			rd_byte <= 8'h00;
			bus.cs_n <= 1'b1;
			bus.wr_n <= 1'b1;
			bus.rd_n <= 1'b1;
			bus.c_d <= 1'b0;
			bus.axis_sel <= 1'b0;
			bus.host_data <= 8'h00;
			bus.host_oe_n <= 1'b1;
		end else begin
			case (state)
				H_IDLE: begin
					if (start) begin
						busy <= 1'b1;
						is_read <= I_PWDATA[CMD_READ_BIT];
						bus.cs_n <= 1'b0;
						bus.c_d <= I_PWDATA[CMD_CD_BIT];
						bus.axis_sel <= I_PWDATA[CMD_AXIS_BIT];
						bus.host_data <= I_PWDATA[7:0];
						bus.host_oe_n <= I_PWDATA[CMD_READ_BIT];
						cnt <= SETUP_CYC - 5'h01;
						state <= H_SETUP;
					end
				end
				H_SETUP: begin
					cnt <= cnt - 5'h01;
					if (cnt_end) begin
						bus.wr_n <= is_read;
						bus.rd_n <= ~is_read;
						cnt <= STROBE_CYC - 5'h01;
						state <= H_STROBE;
					end
				end
				H_STROBE: begin
					cnt <= cnt - 5'h01;
					if (cnt_end) begin
						if (is_read)
							rd_byte <= bus.data_bus;
						bus.wr_n <= 1'b1;
						bus.rd_n <= 1'b1;
						state <= H_HOLD;
					end
				end
				H_HOLD: begin
					bus.cs_n <= 1'b1;
					bus.host_oe_n <= 1'b1;
					cnt <= GAP_CYC - 5'h01;
					state <= H_GAP;
				end
				H_GAP: begin
					cnt <= cnt - 5'h01;
					if (cnt_end) begin
						busy <= 1'b0;
						state <= H_IDLE;
					end
				end
				default: state <= H_IDLE;
			endcase
		end
	end
endmodule

// ---- verification/quad_bus_assertions.sv ----
// Checks on the strobed host bus between the two ends
`timescale 1ns/1ps
module quad_bus_assertions(
	input wire logic I_CLOCK, // System clock
	input wire logic I_RST_B, // Async reset, active low
	input wire logic cs_n, // Chip select
	input wire logic wr_n, // Write strobe
	input wire logic rd_n, // Read strobe
	input wire logic c_d, // Control/data select
	input wire logic axis_sel, // Axis select
	input wire logic [7:0] host_data, // Host drive value
	input wire logic host_oe_n, // Host drive enable
	input wire logic [7:0] dev_data, // Device drive value
	input wire logic dev_oe_n, // Device drive enable
	input wire logic [7:0] data_bus // Resolved bus
);
	default clocking cb @(posedge I_CLOCK); endclocking
	default disable iff (!I_RST_B);
	property p_no_fight;
		!(!dev_oe_n && !host_oe_n);
	endproperty
	property p_dev_drive;
		dev_oe_n == !$past(!cs_n && !rd_n);
	endproperty
	property p_wr_cs;
		!wr_n |-> !cs_n && !host_oe_n;
	endproperty
	property p_rd_cs;
		!rd_n |-> !cs_n && host_oe_n;
	endproperty
	property p_rise_cs;
		$rose(wr_n) || $rose(rd_n) |-> !cs_n;
	endproperty
	property p_hold;
		!cs_n && $past(!cs_n) |-> $stable({c_d, axis_sel});
	endproperty
	property p_data;
		!wr_n |-> $stable(host_data);
	endproperty
	property p_wr_width;
		$fell(wr_n) |-> (!wr_n) [*8];
	endproperty
	property p_rd_width;
		$fell(rd_n) |-> (!rd_n) [*8];
	endproperty
	property p_drive_value;
		!dev_oe_n |-> data_bus == dev_data;
	endproperty
	property p_cs_span;
		$fell(cs_n) |-> ##[20:40] $rose(cs_n);
	endproperty
	a_no_fight: assert property (p_no_fight)
		else $error("both ends drive the data bus");
	a_dev_drive: assert property (p_dev_drive)
		else $error("device drive not tied to read strobe");
	a_wr_cs: assert property (p_wr_cs)
		else $error("write strobe without select or drive");
	a_rd_cs: assert property (p_rd_cs)
		else $error("read strobe without select");
	a_rise_cs: assert property (p_rise_cs)
		else $error("strobe ended after select rose");
	a_hold: assert property (p_hold)
		else $error("select lines moved during access");
	a_data: assert property (p_data)
		else $error("write data moved during strobe");
	a_wr_width: assert property (p_wr_width)
		else $error("write strobe too short");
	a_rd_width: assert property (p_rd_width)
		else $error("read strobe too short");
	a_drive_value: assert property (p_drive_value)
		else $error("bus does not carry device byte");
	a_cs_span: assert property (p_cs_span)
		else $error("select low for wrong length");
	c_ctl_wr: cover property ($rose(wr_n) && c_d);
	c_dat_rd: cover property ($rose(rd_n) && !c_d);
	c_flag_rd: cover property ($rose(rd_n) && c_d);
endmodule

// ---- verification/dual_axis_quadrature_counter_tb.sv ----
// Bench for the counter device driven through its APB host end
`timescale 1ns/1ps
module dual_axis_quadrature_counter_tb;
	import quad_counter_pkg::*;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic filter_clock_input = 1'b0;
	logic [1:0] a = 2'h0;
	logic [1:0] b = 2'h0;
	logic [1:0] ld = 2'h3;
	logic [1:0] rg = 2'h3;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic [7:0] padr = 8'h00;
	logic [31:0] pwd = 32'h0000_0000;
	logic [31:0] prd, rdat;
	logic prdy, perr, rerr;
	logic [1:0] f1, f2;
	logic [7:0] fb;
	logic [23:0] v;
	int error_cnt = 0;
	int samples_checked = 0;
	int cyc = 0;
	quad_bus_if bus_i();
	always #2 clk = ~clk;
	// Free-running filter clock at half the system rate
	always @(posedge clk) filter_clock_input <= ~filter_clock_input;
	quad_counter_device u_quad_counter_device(.I_CLOCK(clk), .I_RST_B(rst_b),
		.I_FILTER_CLOCK_INPUT(filter_clock_input), .I_CHANNEL_A_INPUT(a),
		.I_CHANNEL_B_INPUT(b), .I_LOAD_INPUT(ld),
		.I_RESET_OR_GATE_INPUT(rg), .O_FLAG_OUTPUT_ONE(f1),
		.O_FLAG_OUTPUT_TWO(f2), .bus(bus_i));
	quad_host_end u_quad_host_end(.I_CLOCK(clk), .I_RST_B(rst_b),
		.I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(padr),
		.I_PWDATA(pwd), .O_PRDATA(prd), .O_PREADY(prdy),
		.O_PSLVERR(perr), .bus(bus_i));
	quad_bus_assertions u_quad_bus_assertions(.I_CLOCK(clk),
		.I_RST_B(rst_b), .cs_n(bus_i.cs_n), .wr_n(bus_i.wr_n),
		.rd_n(bus_i.rd_n), .c_d(bus_i.c_d), .axis_sel(bus_i.axis_sel),
		.host_data(bus_i.host_data), .host_oe_n(bus_i.host_oe_n),
		.dev_data(bus_i.dev_data), .dev_oe_n(bus_i.dev_oe_n),
		.data_bus(bus_i.data_bus));
	task final_report;
		if (error_cnt == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			error_cnt++;
			final_report;
		end
	end
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			error_cnt++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	endtask
	task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		padr <= ad;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		// Only the bench timeout ends a wait for ready
		do begin
			@(posedge clk);
		end while (prdy !== 1'b1);
		rdat = prd;
		rerr = perr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	// Waits on the busy bit, so each strobe cycle ends before the next
	task cmd(input logic [10:0] c);
		apb(1'b1, HOST_CMD_OFS, {21'h0, c});
		do begin
			apb(1'b0, HOST_STAT_OFS, 32'h0000_0000);
		end while (rdat[0] !== 1'b0);
	endtask
	task wr(input logic cd, input logic ax, input logic [7:0] d);
		cmd({1'b0, ax, cd, d});
	endtask
	task rd(input logic cd, input logic ax, output logic [7:0] d);
		cmd({1'b1, ax, cd, 8'h00});
		d = rdat[15:8];
	endtask
	task lat(input logic ax, input logic [7:0] c, output logic [23:0] q);
		wr(1'b1, ax, c);
		rd(1'b0, ax, q[7:0]);
		rd(1'b0, ax, q[15:8]);
		rd(1'b0, ax, q[23:16]);
	endtask
	task pulse(input int ax, input int n);
		repeat (n) begin
			@(posedge clk);
			a[ax] <= 1'b1;
			repeat (4) @(posedge clk);
			a[ax] <= 1'b0;
			repeat (4) @(posedge clk);
		end
	endtask
	task quad(input int ax);
		logic [7:0] s;
		s = 8'b10_11_01_00;
		for (int k = 0; k < 4; k++) begin
			@(posedge clk);
			a[ax] <= s[7 - 2 * k];
			b[ax] <= s[6 - 2 * k];
			repeat (16) @(posedge clk);
		end
	endtask
	initial begin
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		apb(1'b0, 8'h08, 32'h0000_0000);
		chk("slverr", {31'h0, rerr}, 32'h0000_0001);
		b[0] <= 1'b1;
		pulse(0, 5);
		lat(1'b0, 8'h09, v);
		chk("x up", v, 24'h00_0005);
		b[1] <= 1'b0;
		pulse(1, 2);
		lat(1'b1, 8'h09, v);
		chk("y down", v, 24'hFF_FFFE);
		rd(1'b1, 1'b1, fb);
		chk("y flags", fb & 8'h26, 8'h02);
		rd(1'b1, 1'b0, fb);
		chk("x flags", fb & 8'h26, 8'h20);
		wr(1'b1, 1'b0, 8'h01);
		wr(1'b0, 1'b0, 8'h12);
		wr(1'b0, 1'b0, 8'h34);
		wr(1'b0, 1'b0, 8'h56);
		wr(1'b1, 1'b0, 8'h05);
		lat(1'b0, 8'h09, v);
		chk("preset", v, 24'h56_3412);
		wr(1'b1, 1'b0, 8'h44);
		chk("cmp pin", f1[0], 1'b0);
		wr(1'b1, 1'b0, 8'h82);
		lat(1'b1, 8'h09, v);
		chk("both", v, 24'h00_0000);
		chk("cmp off", f1[0], 1'b1);
		wr(1'b1, 1'b1, 8'h44);
		chk("y cmp pin", f1[1], 1'b0);
		wr(1'b1, 1'b0, 8'h46);
		rg[0] <= 1'b0;
		pulse(0, 3);
		rg[0] <= 1'b1;
		pulse(0, 2);
		lat(1'b0, 8'h09, v);
		chk("gate", v, 24'h00_0002);
		ld[0] <= 1'b0;
		repeat (8) @(posedge clk);
		ld[0] <= 1'b1;
		lat(1'b0, 8'h09, v);
		chk("dir load", v, 24'h56_3412);
		wr(1'b1, 1'b0, 8'h21);
		b[0] <= 1'b0;
		wr(1'b1, 1'b0, 8'h02);
		quad(0);
		lat(1'b0, 8'h09, v);
		chk("quad", v, 24'h00_0004);
		wr(1'b1, 1'b0, 8'h41);
		wr(1'b1, 1'b0, 8'h69);
		chk("dir pin", f2[0], 1'b1);
		quad(0);
		// Index low for eight filter ticks, latch gets the count
		ld[0] <= 1'b0;
		repeat (16) @(posedge clk);
		ld[0] <= 1'b1;
		lat(1'b0, 8'h01, v);
		chk("index", v, 24'h00_0008);
		// Index reset on the reset/gate input, active low
		wr(1'b1, 1'b0, 8'h65);
		rg[0] <= 1'b0;
		repeat (8) @(posedge clk);
		rg[0] <= 1'b1;
		lat(1'b0, 8'h09, v);
		chk("idx reset", v, 24'h00_0000);
		wr(1'b1, 1'b0, 8'h70);
		quad(0);
		rg[0] <= 1'b0;
		repeat (8) @(posedge clk);
		rg[0] <= 1'b1;
		lat(1'b0, 8'h09, v);
		chk("dir reset", v, 24'h00_0000);
		wr(1'b1, 1'b0, 8'h10);
		chk("err pin off", f2[0], 1'b0);
		// Both channels move at once: a decode error
		a[0] <= 1'b1;
		b[0] <= 1'b1;
		repeat (16) @(posedge clk);
		rd(1'b1, 1'b0, fb);
		chk("err flag", fb & 8'h10, 8'h10);
		chk("err pin", f2[0], 1'b1);
		final_report;
	end
endmodule
